//--- codc_regs.sv
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/1ps
// Operation
// - Shared divider is 8 bits; ratio equals value plus one, 1 to 256.
// - One divider setting serves channels 0 and 1; resets to 1, ratio two.
// - Format select: 0 off, 1 AC differential, 2 HCSL, 3 CMOS; resets 1.
// - Differential first mode sets tail current 4/6/8/16-or-8 mA; resets 2.
// - CMOS: first mode drives positive pin, second negative pin, four states.
// - Differential second mode picks HCSL load: none/50/100/200 ohm; resets 0.
// - Control layout: format 6:5, first mode 4:3, second mode 2:1, bit 0 reserved.
// - Channel 2 bit 7 is read-write, resets one, nonvolatile; host writes zero.
// - Channel 2 control governs output 2 only; its fields are nonvolatile.
module codc_regs (
  input wire logic CLK_SYS_IN,
  input wire logic RST_B_IN,
  input wire logic HSEL_IN,
  input wire logic [codc_pkg::ADDR_W-1:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [2:0] HSIZE_IN,
  input wire logic [codc_pkg::DATA_W-1:0] HWDATA_IN,
  input wire logic HREADY_IN,
  output logic HREADYOUT_OUT,
  output logic [codc_pkg::DATA_W-1:0] HRDATA_OUT,
  output logic HRESP_OUT,
  input wire logic NV_LOAD_IN,
  input wire codc_pkg::codc_nv_s NV_DATA_IN,
  output codc_pkg::codc_nv_s NV_IMAGE_OUT,
  output logic [8:0] DIV_RATIO_OUT,
  output codc_pkg::codc_drv_s CH2_DRV_OUT,
  output codc_pkg::codc_drv_s CH3_DRV_OUT
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] div;
    codc_pkg::codc_ctl_s ctl2;
    codc_pkg::codc_ctl_s ctl3;
    logic wr_pend;
    codc_pkg::codc_reg_e wr_reg;
    logic hreadyout;
    logic [codc_pkg::DATA_W-1:0] hrdata;
    logic [8:0] ratio;
    codc_pkg::codc_drv_s drv2;
    codc_pkg::codc_drv_s drv3;
    codc_pkg::codc_nv_s nv;
  } codc_st_s;

  localparam codc_pkg::codc_ctl_s CTL2_RST = '{
    reserved_bit: codc_pkg::CH2_RSV_RST, fmt: codc_pkg::FMT_RST,
    mode1: codc_pkg::MODE1_RST, mode2: codc_pkg::MODE2_RST, rsv0: 1'b0};
  localparam codc_pkg::codc_ctl_s CTL3_RST = '{
    reserved_bit: 1'b0, fmt: codc_pkg::FMT_RST,
    mode1: codc_pkg::MODE1_RST, mode2: codc_pkg::MODE2_RST, rsv0: 1'b0};

  codc_st_s st_q;
  codc_st_s st_d;
  codc_pkg::codc_ctl_s [1:0] dec_ctl;
  codc_pkg::codc_drv_s [1:0] dec_drv;
  logic take;
  logic [7:0] wbyte;

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  function automatic logic [codc_pkg::DATA_W-1:0] read_word(
    input codc_pkg::codc_reg_e r,
    input logic [7:0] div,
    input codc_pkg::codc_ctl_s c2,
    input codc_pkg::codc_ctl_s c3
  );
    logic [7:0] b;
    b = 8'h00;
    unique case (r)
      codc_pkg::REG_DIV: b = div;
      codc_pkg::REG_CTL2: b = c2 & codc_pkg::CTL2_WR_MASK;
      codc_pkg::REG_CTL3: b = c3 & codc_pkg::CTL3_WR_MASK;
      codc_pkg::REG_NONE: b = 8'h00;
    endcase
    return {24'h000000, b};
  endfunction

  // ----------------------------------------------------------------
  // Channel decoders
  // ----------------------------------------------------------------
  assign dec_ctl[0] = st_q.ctl2;
  assign dec_ctl[1] = st_q.ctl3;

  for (genvar i = 0; i < 2; i++) begin : g_chan
    codc_chan_decode u_dec (
      .ctl_in(dec_ctl[i]),
      .drv_out(dec_drv[i])
    );
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  assign take = HSEL_IN && HREADY_IN &&
                ((HTRANS_IN == codc_pkg::HTRANS_NONSEQ) || (HTRANS_IN == codc_pkg::HTRANS_SEQ));
  assign wbyte = HWDATA_IN[7:0];

  always_comb begin
    st_d = st_q;
    st_d.hreadyout = 1'b1;
    // Image load first so a bus write in the same cycle wins
    if (NV_LOAD_IN) begin
      st_d.div = NV_DATA_IN.div;
      st_d.ctl2 = NV_DATA_IN.ctl2 & codc_pkg::CTL2_WR_MASK;
      st_d.ctl3 = NV_DATA_IN.ctl3 & codc_pkg::CTL3_WR_MASK;
    end
    if (st_q.wr_pend) begin
      unique case (st_q.wr_reg)
        codc_pkg::REG_DIV: st_d.div = wbyte;
        codc_pkg::REG_CTL2: st_d.ctl2 = wbyte & codc_pkg::CTL2_WR_MASK;
        codc_pkg::REG_CTL3: st_d.ctl3 = wbyte & codc_pkg::CTL3_WR_MASK;
        codc_pkg::REG_NONE: st_d.div = st_d.div;
      endcase
    end
    st_d.wr_pend = 1'b0;
    st_d.wr_reg = codc_pkg::REG_NONE;
    st_d.hrdata = '0;
    if (take) begin
      st_d.wr_pend = HWRITE_IN;
      st_d.wr_reg = codc_pkg::reg_decode(HADDR_IN);
      if (!HWRITE_IN) begin
        st_d.hrdata = read_word(codc_pkg::reg_decode(HADDR_IN), st_d.div, st_d.ctl2,
                                st_d.ctl3);
      end
    end
    st_d.ratio = {1'b0, st_d.div} + codc_pkg::RATIO_STEP;
    st_d.drv2 = dec_drv[0];
    st_d.drv3 = dec_drv[1];
    st_d.nv.div = st_d.div;
    st_d.nv.ctl2 = st_d.ctl2;
    st_d.nv.ctl3 = st_d.ctl3;
  end

  always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      st_q <= '{
        div: codc_pkg::DIV_RST,
        ctl2: CTL2_RST,
        ctl3: CTL3_RST,
        wr_pend: 1'b0,
        wr_reg: codc_pkg::REG_NONE,
        hreadyout: 1'b1,
        hrdata: '0,
        ratio: {1'b0, codc_pkg::DIV_RST} + codc_pkg::RATIO_STEP,
        drv2: '0,
        drv3: '0,
        nv: '{div: codc_pkg::DIV_RST, ctl2: CTL2_RST, ctl3: CTL3_RST}
      };
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign HREADYOUT_OUT = st_q.hreadyout;
  assign HRDATA_OUT = st_q.hrdata;
  assign HRESP_OUT = 1'b0;
  assign DIV_RATIO_OUT = st_q.ratio;
  assign CH2_DRV_OUT = st_q.drv2;
  assign CH3_DRV_OUT = st_q.drv3;
  assign NV_IMAGE_OUT = st_q.nv;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RST_B_IN);

  logic rd_div_q;
  logic rd_ctl2_q;
  logic rd_ctl3_q;
  logic rd_none_q;
  logic rd_any_q;
  always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      rd_div_q <= 1'b0;
      rd_ctl2_q <= 1'b0;
      rd_ctl3_q <= 1'b0;
      rd_none_q <= 1'b0;
      rd_any_q <= 1'b0;
    end else begin
      rd_div_q <= take && !HWRITE_IN && (codc_pkg::reg_decode(HADDR_IN) == codc_pkg::REG_DIV);
      rd_ctl3_q <= take && !HWRITE_IN && (codc_pkg::reg_decode(HADDR_IN) == codc_pkg::REG_CTL3);
      rd_none_q <= take && !HWRITE_IN && (codc_pkg::reg_decode(HADDR_IN) == codc_pkg::REG_NONE);
      rd_ctl2_q <= take && !HWRITE_IN && (codc_pkg::reg_decode(HADDR_IN) == codc_pkg::REG_CTL2);
      rd_any_q <= take && !HWRITE_IN;
    end
  end

  div_ratio_a: assert property (DIV_RATIO_OUT == {1'b0, st_q.div} + codc_pkg::RATIO_STEP)
    else $error("divide ratio not value plus one");

  div_write_a: assert property (
    (st_q.wr_pend && st_q.wr_reg == codc_pkg::REG_DIV && !NV_LOAD_IN)
      |=> (DIV_RATIO_OUT == {1'b0, $past(HWDATA_IN[7:0])} + codc_pkg::RATIO_STEP))
    else $error("divider write not reflected in ratio");

  div_read_a: assert property (rd_div_q |-> HRDATA_OUT == {24'h000000, st_q.div})
    else $error("divider read back mismatch");

  fmt_off_a: assert property ($past(RST_B_IN) |->
    (($past(st_q.ctl2.fmt) == codc_pkg::FMT_OFF) == !CH2_DRV_OUT.en))
    else $error("channel 2 enable disagrees with format");

  tail_hcsl_a: assert property (
    ($past(st_q.ctl3.fmt) == codc_pkg::FMT_HCSL && $past(st_q.ctl3.mode1) == 2'h3)
      |-> CH3_DRV_OUT.tail_ma == codc_pkg::TAIL_16MA)
    else $error("HCSL top tail current wrong");

  cmos_pins_a: assert property (
    CH2_DRV_OUT.is_cmos |-> (CH2_DRV_OUT.tail_ma == 5'h00) &&
      (CH2_DRV_OUT.pos_pin.inv == ($past(st_q.ctl2.mode1) == codc_pkg::PIN_PU_INV)) &&
      (CH2_DRV_OUT.neg_pin.oe == ($past(st_q.ctl2.mode2) != codc_pkg::PIN_PD_TRI)))
    else $error("CMOS pin states wrong");

  load_50r_a: assert property (
    (CH2_DRV_OUT.is_hcsl && $past(st_q.ctl2.mode2) == 2'h1)
      |-> CH2_DRV_OUT.load_ohm == codc_pkg::LOAD_50R)
    else $error("HCSL load not fifty ohm");

  ctl3_rsv_a: assert property (rd_ctl3_q |-> HRDATA_OUT[7] == 1'b0 && HRDATA_OUT[0] == 1'b0)
    else $error("channel 3 reserved bits read nonzero");

  ch2_rsv_wr_a: assert property (
    (st_q.wr_pend && st_q.wr_reg == codc_pkg::REG_CTL2)
      |=> st_q.ctl2.reserved_bit == $past(HWDATA_IN[7]) && NV_IMAGE_OUT.ctl2.reserved_bit
        == st_q.ctl2.reserved_bit)
    else $error("channel 2 bit 7 not stored");

  nv_image_a: assert property (NV_IMAGE_OUT == {st_q.div, st_q.ctl2, st_q.ctl3})
    else $error("nonvolatile image out of step");

  unmapped_a: assert property (rd_none_q |-> HRDATA_OUT == '0 && HRESP_OUT == 1'b0)
    else $error("unmapped read not zero");

  // ----------------------------------------------------------------
  // Read back and driver checks
  // ----------------------------------------------------------------
  rdata_idle_a: assert property (!rd_any_q |-> HRDATA_OUT == '0)
    else $error("read data not zero outside data phase");

  rdata_upper_a: assert property (HRDATA_OUT[31:8] == 24'h000000)
    else $error("read data upper lanes not zero");

  ctl2_read_a: assert property (
    rd_ctl2_q |-> HRDATA_OUT[7] == st_q.ctl2.reserved_bit && HRDATA_OUT[0] == 1'b0)
    else $error("channel 2 read back mismatch");

  ctl3_fields_a: assert property (
    rd_ctl3_q |-> HRDATA_OUT[6:5] == st_q.ctl3.fmt && HRDATA_OUT[4:3] == st_q.ctl3.mode1 &&
      HRDATA_OUT[2:1] == st_q.ctl3.mode2)
    else $error("channel 3 field layout wrong");

  rsv_store_a: assert property (
    !st_q.ctl2.rsv0 && !st_q.ctl3.rsv0 && !st_q.ctl3.reserved_bit)
    else $error("reserved bit held a one");

  ch3_off_a: assert property ($past(RST_B_IN) |->
    (($past(st_q.ctl3.fmt) == codc_pkg::FMT_OFF) == !CH3_DRV_OUT.en))
    else $error("channel 3 enable disagrees with format");

  ac_tail_a: assert property (
    (CH2_DRV_OUT.is_diff && !CH2_DRV_OUT.is_hcsl && $past(st_q.ctl2.mode1) == 2'h3)
      |-> CH2_DRV_OUT.tail_ma == codc_pkg::TAIL_8MA)
    else $error("AC differential top tail current wrong");

  ac_no_load_a: assert property (
    (CH3_DRV_OUT.is_diff && !CH3_DRV_OUT.is_hcsl)
      |-> CH3_DRV_OUT.load_ohm == codc_pkg::LOAD_NONE)
    else $error("AC differential reports a load");

  cmos_tri_a: assert property (
    (CH3_DRV_OUT.is_cmos && $past(st_q.ctl3.mode1) == codc_pkg::PIN_PD_TRI)
      |-> !CH3_DRV_OUT.pos_pin.oe && !CH3_DRV_OUT.pos_pin.pwr)
    else $error("CMOS positive pin not tristated");

  cmos_neg_pwr_a: assert property (
    CH3_DRV_OUT.is_cmos |-> CH3_DRV_OUT.neg_pin.pwr == $past(st_q.ctl3.mode2[1]))
    else $error("CMOS negative pin power wrong");

  ratio_range_a: assert property (DIV_RATIO_OUT != 9'h000)
    else $error("divide ratio out of range");

  nv_load_a: assert property (
    (NV_LOAD_IN && !(st_q.wr_pend && st_q.wr_reg == codc_pkg::REG_DIV))
      |=> st_q.div == $past(NV_DATA_IN.div))
    else $error("divider not loaded from image");

  bus_ready_a: assert property (HREADYOUT_OUT ##1 HREADYOUT_OUT)
    else $error("slave inserted wait state");

  div_wr_c: cover property (st_q.wr_pend && st_q.wr_reg == codc_pkg::REG_DIV);
  ctl3_rd_c: cover property (rd_ctl3_q);
  cmos_c: cover property (CH3_DRV_OUT.is_cmos);
  hcsl_c: cover property (CH2_DRV_OUT.is_hcsl ##1 CH2_DRV_OUT.load_ohm == codc_pkg::LOAD_200R);
  nv_c: cover property (NV_LOAD_IN);

endmodule

//--- codc_pkg.sv
package codc_pkg;

  // ----------------------------------------------------------------
  // Bus and register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic [ADDR_W-1:0] WORD_BYTES = 32'h4;
  localparam logic [7:0] IDX_DIV = 8'h21;
  localparam logic [7:0] IDX_CTL2 = 8'h22;
  localparam logic [7:0] IDX_CTL3 = 8'h23;
  localparam logic [ADDR_W-1:0] ADDR_DIV = 32'(IDX_DIV) * WORD_BYTES;
  localparam logic [ADDR_W-1:0] ADDR_CTL2 = 32'(IDX_CTL2) * WORD_BYTES;
  localparam logic [ADDR_W-1:0] ADDR_CTL3 = 32'(IDX_CTL3) * WORD_BYTES;

  // ----------------------------------------------------------------
  // Reset values and writable bits
  // ----------------------------------------------------------------
  localparam logic [7:0] DIV_RST = 8'h01;
  localparam logic [1:0] FMT_RST = 2'h1;
  localparam logic [1:0] MODE1_RST = 2'h2;
  localparam logic [1:0] MODE2_RST = 2'h0;
  localparam logic CH2_RSV_RST = 1'b1;
  localparam logic [7:0] CTL2_WR_MASK = 8'hFE;
  localparam logic [7:0] CTL3_WR_MASK = 8'h7E;
  localparam logic [8:0] RATIO_STEP = 9'h001;

  // ----------------------------------------------------------------
  // Driver figures
  // ----------------------------------------------------------------
  localparam logic [4:0] TAIL_4MA = 5'h04;
  localparam logic [4:0] TAIL_6MA = 5'h06;
  localparam logic [4:0] TAIL_8MA = 5'h08;
  localparam logic [4:0] TAIL_16MA = 5'h10;
  localparam logic [7:0] LOAD_NONE = 8'h00;
  localparam logic [7:0] LOAD_50R = 8'h32;
  localparam logic [7:0] LOAD_100R = 8'h64;
  localparam logic [7:0] LOAD_200R = 8'hC8;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {FMT_OFF, FMT_AC_DIFF, FMT_HCSL, FMT_CMOS} codc_fmt_e;
  typedef enum logic [1:0] {PIN_PD_TRI, PIN_PD_LOW, PIN_PU_INV, PIN_PU_TRUE} codc_pin_e;
  typedef enum logic [1:0] {REG_NONE, REG_DIV, REG_CTL2, REG_CTL3} codc_reg_e;

  typedef struct packed {
    logic reserved_bit;
    logic [1:0] fmt;
    logic [1:0] mode1;
    logic [1:0] mode2;
    logic rsv0;
  } codc_ctl_s;

  typedef struct packed {
    logic pwr;
    logic oe;
    logic inv;
  } codc_pin_s;

  typedef struct packed {
    logic en;
    logic is_diff;
    logic is_hcsl;
    logic is_cmos;
    logic [4:0] tail_ma;
    logic [7:0] load_ohm;
    codc_pin_s pos_pin;
    codc_pin_s neg_pin;
  } codc_drv_s;

  typedef struct packed {
    logic [7:0] div;
    codc_ctl_s ctl2;
    codc_ctl_s ctl3;
  } codc_nv_s;

  function automatic codc_reg_e reg_decode(input logic [ADDR_W-1:0] addr);
    if (addr == ADDR_DIV) begin
      return REG_DIV;
    end else if (addr == ADDR_CTL2) begin
      return REG_CTL2;
    end else if (addr == ADDR_CTL3) begin
      return REG_CTL3;
    end
    return REG_NONE;
  endfunction

endpackage

//--- codc_chan_decode.sv
`timescale 1ns/1ps
module codc_chan_decode (
  input wire codc_pkg::codc_ctl_s ctl_in,
  output codc_pkg::codc_drv_s drv_out
);

  function automatic codc_pkg::codc_pin_s pin_decode(input logic [1:0] code);
    codc_pkg::codc_pin_s p;
    p.pwr = (code == codc_pkg::PIN_PU_INV) || (code == codc_pkg::PIN_PU_TRUE);
    p.oe = (code != codc_pkg::PIN_PD_TRI);
    p.inv = (code == codc_pkg::PIN_PU_INV);
    return p;
  endfunction

  always_comb begin
    drv_out = '0;
    unique case (codc_pkg::codc_fmt_e'(ctl_in.fmt))
      codc_pkg::FMT_OFF: begin
        drv_out = '0;
      end
      codc_pkg::FMT_AC_DIFF, codc_pkg::FMT_HCSL: begin
        drv_out.en = 1'b1;
        drv_out.is_diff = 1'b1;
        drv_out.is_hcsl = (ctl_in.fmt == codc_pkg::FMT_HCSL);
        unique case (ctl_in.mode1)
          2'h0: drv_out.tail_ma = codc_pkg::TAIL_4MA;
          2'h1: drv_out.tail_ma = codc_pkg::TAIL_6MA;
          2'h2: drv_out.tail_ma = codc_pkg::TAIL_8MA;
          2'h3: drv_out.tail_ma = drv_out.is_hcsl ? codc_pkg::TAIL_16MA : codc_pkg::TAIL_8MA;
        endcase
        // Termination only exists on the HCSL stage
        if (drv_out.is_hcsl) begin
          unique case (ctl_in.mode2)
            2'h0: drv_out.load_ohm = codc_pkg::LOAD_NONE;
            2'h1: drv_out.load_ohm = codc_pkg::LOAD_50R;
            2'h2: drv_out.load_ohm = codc_pkg::LOAD_100R;
            2'h3: drv_out.load_ohm = codc_pkg::LOAD_200R;
          endcase
        end
      end
      codc_pkg::FMT_CMOS: begin
        drv_out.en = 1'b1;
        drv_out.is_cmos = 1'b1;
        drv_out.pos_pin = pin_decode(ctl_in.mode1);
        drv_out.neg_pin = pin_decode(ctl_in.mode2);
      end
    endcase
  end

endmodule

//--- codc_regs_test.sv
`timescale 1ns/1ps
module codc_regs_test;
  // --------------------------------------------------------------
  // Stimulus and observed signals
  // --------------------------------------------------------------
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic [31:0] hrdata;
  logic hresp;
  logic nv_load = 1'b0;
  codc_pkg::codc_nv_s nv_data = '0;
  codc_pkg::codc_nv_s nv_image;
  logic [8:0] div_ratio;
  codc_pkg::codc_drv_s ch2_drv;
  codc_pkg::codc_drv_s ch3_drv;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;

  always #2 clk = ~clk;

  codc_regs uut (
    .CLK_SYS_IN(clk), .RST_B_IN(rst_b), .HSEL_IN(hsel), .HADDR_IN(haddr),
    .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(hsize), .HWDATA_IN(hwdata),
    .HREADY_IN(hreadyout), .HREADYOUT_OUT(hreadyout), .HRDATA_OUT(hrdata),
    .HRESP_OUT(hresp), .NV_LOAD_IN(nv_load), .NV_DATA_IN(nv_data),
    .NV_IMAGE_OUT(nv_image), .DIV_RATIO_OUT(div_ratio), .CH2_DRV_OUT(ch2_drv),
    .CH3_DRV_OUT(ch3_drv)
  );

  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task automatic complete_run();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      complete_run();
    end
  end

  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("unexpected %s: expected %h, seen %h", name, e, g);
      error_cnt++;
    end
  endtask

  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= codc_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= a;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask

  task automatic rd_chk(input string name, input logic [31:0] a, input logic [31:0] e);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    chk(name, e, r);
  endtask

  function automatic logic [2:0] pin(input logic [1:0] m);
    case (m)
      2'h0: return 3'h0;
      2'h1: return 3'h2;
      2'h2: return 3'h7;
      default: return 3'h6;
    endcase
  endfunction

  function automatic codc_pkg::codc_drv_s exp_drv(input logic [1:0] f, m1, m2);
    codc_pkg::codc_drv_s d;
    logic [4:0] tail[4];
    logic [7:0] load[4];
    tail = '{codc_pkg::TAIL_4MA, codc_pkg::TAIL_6MA, codc_pkg::TAIL_8MA, codc_pkg::TAIL_8MA};
    load = '{codc_pkg::LOAD_NONE, codc_pkg::LOAD_50R, codc_pkg::LOAD_100R,
             codc_pkg::LOAD_200R};
    d = '0;
    d.en = (f != 2'h0);
    d.is_diff = (f == 2'h1) || (f == 2'h2);
    d.is_hcsl = (f == 2'h2);
    d.is_cmos = (f == 2'h3);
    if (d.is_diff) begin
      d.tail_ma = (d.is_hcsl && m1 == 2'h3) ? codc_pkg::TAIL_16MA : tail[m1];
    end
    if (d.is_hcsl) begin
      d.load_ohm = load[m2];
    end
    if (d.is_cmos) begin
      d.pos_pin = pin(m1);
      d.neg_pin = pin(m2);
    end
    return d;
  endfunction

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic do_reset();
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    chk("hreadyout", 32'h1, {31'h0, hreadyout});
    chk("ch2 drv", 32'h0, {9'h0, ch2_drv});
    chk("ratio", 32'h2, {23'h0, div_ratio});
    rst_b <= 1'b1;
  endtask

  task automatic test_reset();
    rd_chk("div", codc_pkg::ADDR_DIV, 32'h01);
    @(posedge clk);
    chk("hrdata idle", 32'h0, hrdata);
    rd_chk("ctl2", codc_pkg::ADDR_CTL2, 32'hB0);
    rd_chk("ctl3", codc_pkg::ADDR_CTL3, 32'h30);
    chk("ratio", 32'h2, {23'h0, div_ratio});
    chk("ch2 drv", {9'h0, exp_drv(2'h1, 2'h2, 2'h0)}, {9'h0, ch2_drv});
    chk("ch3 drv", {9'h0, exp_drv(2'h1, 2'h2, 2'h0)}, {9'h0, ch3_drv});
    chk("nv image", 32'h01B030, {8'h0, nv_image});
  endtask

  task automatic test_div();
    logic [7:0] v[3];
    v = '{8'h00, 8'hFF, 8'h5A};
    foreach (v[i]) begin
      wr(codc_pkg::ADDR_DIV, {24'hFFFFFF, v[i]});
      rd_chk("div", codc_pkg::ADDR_DIV, {24'h0, v[i]});
      chk("ratio", {24'h0, v[i]} + 32'h1, {23'h0, div_ratio});
    end
  endtask

  task automatic test_fmt();
    logic [1:0] m;
    for (int f = 0; f < 4; f++) begin
      for (int k = 0; k < 4; k++) begin
        m = 2'(k);
        wr(codc_pkg::ADDR_CTL3, {25'h0, 2'(f), m, ~m, 1'b0});
        wr(codc_pkg::ADDR_CTL2, {25'h0, 2'(f), m, m, 1'b0});
        repeat (2) @(posedge clk);
        chk("ch3 drv", {9'h0, exp_drv(2'(f), m, ~m)}, {9'h0, ch3_drv});
        chk("ch2 drv", {9'h0, exp_drv(2'(f), m, m)}, {9'h0, ch2_drv});
      end
    end
  endtask

  task automatic test_rsv();
    wr(codc_pkg::ADDR_CTL2, 32'hFF);
    rd_chk("ctl2", codc_pkg::ADDR_CTL2, 32'hFE);
    wr(codc_pkg::ADDR_CTL3, 32'hFF);
    rd_chk("ctl3", codc_pkg::ADDR_CTL3, 32'h7E);
    wr(codc_pkg::ADDR_CTL2, 32'h00);
    rd_chk("ctl2", codc_pkg::ADDR_CTL2, 32'h00);
    wr(32'h90, 32'hFF);
    rd_chk("unmapped", 32'h90, 32'h00);
    rd_chk("div", codc_pkg::ADDR_DIV, 32'h5A);
  endtask

  task automatic test_nv();
    @(posedge clk);
    nv_load <= 1'b1;
    nv_data <= 24'h7FFFFF;
    @(posedge clk);
    nv_load <= 1'b0;
    @(posedge clk);
    chk("nv image", 32'h7FFE7E, {8'h0, nv_image});
    chk("ratio", 32'h80, {23'h0, div_ratio});
    rd_chk("ctl2", codc_pkg::ADDR_CTL2, 32'hFE);
  endtask

  initial begin
    do_reset();
    test_reset();
    test_div();
    test_fmt();
    test_rsv();
    test_nv();
    do_reset();
    test_reset();
    complete_run();
  end
endmodule
